// ### src/rsw_top.sv
// Functional notes
// - every reset returns all settings to defaults
// - main RC divided clock when enabled or when the primary watchdog runs on slow RC
// - 12-bit down counter loaded from reload value
// - counter steps on time base divided 128
// - reload value reads 0xFFF after reset
// - reset generation enable is 1 after reset
// - mode register write restarts the watchdog
//
// Our own choices: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/100ps
`include "rsw_defs.svh"
module rsw_top (
  input  wire logic              clk_sys_i,
  input  wire logic              sys_rst_i,
  input  wire logic              slow_clk_i,
  input  wire logic              rc_div_clk_i,
  input  wire logic              main_rc_oscillator_enable_i,
  input  wire logic              primary_watchdog_on_slow_rc_i,
  input  wire rsw_pkg::rsw_addr_t s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire rsw_pkg::rsw_word_t s_axi_wdata,
  input  wire rsw_pkg::rsw_strb_t s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire rsw_pkg::rsw_addr_t s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output rsw_pkg::rsw_word_t     s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   irq_o,
  output logic                   fault_o,
  output logic                   wdt_reset_o
);
  import rsw_pkg::*;

  function automatic logic hit(input rsw_addr_t a, input rsw_addr_t off);
    hit = (a[7:2] == off[7:2]);
  endfunction

  function automatic rsw_word_t merge(input rsw_word_t old, input rsw_word_t nw, input rsw_strb_t s);
    rsw_word_t r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    merge = r;
  endfunction

  // pin inputs through two flops
  logic [3:0] pins_s;
  rsw_sync #(.WIDTH(4)) u_sync (
    .clk_sys_i (clk_sys_i),
    .sys_rst_i (sys_rst_i),
    .async_i   ({primary_watchdog_on_slow_rc_i, main_rc_oscillator_enable_i, rc_div_clk_i, slow_clk_i}),
    .sync_o    (pins_s)
  );

  wire use_rc = pins_s[2] | pins_s[3];

  // write channel
  logic      aw_held_q;
  logic      w_held_q;
  rsw_addr_t awaddr_q;
  rsw_word_t wdata_q;
  rsw_strb_t wstrb_q;
  wire       aw_take  = s_axi_awvalid & s_axi_awready;
  wire       w_take   = s_axi_wvalid & s_axi_wready;
  wire       wr_do    = aw_held_q & w_held_q & ~s_axi_bvalid;
  wire       b_done   = s_axi_bvalid & s_axi_bready;
  wire       wr_ctrl  = wr_do & hit(awaddr_q, `RSW_CTRL_OFF);
  wire       wr_mode  = wr_do & hit(awaddr_q, `RSW_MODE_OFF);
  wire       wr_mask  = wr_do & hit(awaddr_q, `RSW_MASK_OFF);
  wire       wr_sts   = wr_do & hit(awaddr_q, `RSW_STAT_OFF);
  wire       wr_cnt   = wr_do & hit(awaddr_q, `RSW_CNT_OFF);
  wire       wr_ok    = wr_ctrl | wr_mode | wr_mask | wr_sts | wr_cnt;

  // read channel
  wire       ar_take  = s_axi_arvalid & s_axi_arready;
  wire       r_done   = s_axi_rvalid & s_axi_rready;
  wire       sel_ctrl = hit(s_axi_araddr, `RSW_CTRL_OFF);
  wire       sel_mode = hit(s_axi_araddr, `RSW_MODE_OFF);
  wire       sel_stat = hit(s_axi_araddr, `RSW_STAT_OFF);
  wire       sel_mask = hit(s_axi_araddr, `RSW_MASK_OFF);
  wire       sel_cnt  = hit(s_axi_araddr, `RSW_CNT_OFF);
  wire       rd_stat  = ar_take & sel_stat;

  // registers
  logic [11:0] reload_q;
  logic        rsten_q;
  logic        dis_q;
  logic [1:0]  stat_q;
  logic [1:0]  mask_q;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic [1:0]  guard_q;
  logic [1:0]  guard_d;
  rsw_state_t  st_q;
  rsw_state_t  st_d;

  rsw_word_t mode_word;
  rsw_word_t mode_new;
  rsw_word_t mask_new;
  assign mode_word = {16'h0000, dis_q, 1'b0, rsten_q, 1'b0, reload_q};
  assign mode_new  = merge(mode_word, wdata_q, wstrb_q);
  assign mask_new  = merge({30'h0, mask_q}, wdata_q, wstrb_q);

  wire [11:0] new_reload = mode_new[`RSW_MODE_RLD_MSB:0];
  wire        new_rsten  = mode_new[`RSW_MODE_RSTEN];
  wire        new_dis    = mode_new[`RSW_MODE_DIS];

  wire ctrl_restart = wr_ctrl & wstrb_q[0] & wdata_q[`RSW_CTRL_RESTART];
  wire restart      = ctrl_restart | wr_mode;
  // a mode write with disable set stops the count
  wire dis_next     = wr_mode ? new_dis : dis_q;

  // time base and prescaler
  logic tick;
  logic slow_edge;
  rsw_prescale u_pre (
    .clk_sys_i   (clk_sys_i),
    .sys_rst_i   (sys_rst_i),
    .use_rc_i    (use_rc),
    .slow_s_i    (pins_s[0]),
    .rc_s_i      (pins_s[1]),
    .restart_i   (restart),
    .tick_o      (tick),
    .slow_edge_o (slow_edge)
  );

  // watchdog state and counter
  wire        run_tick = (st_q == RSW_ST_RUN) & tick;
  // expiry on the tick that would reach zero
  wire        expire   = run_tick & (cnt_q <= 12'h001);
  wire [11:0] load_val = wr_mode ? new_reload : reload_q;

  always_comb begin
    st_d  = st_q;
    cnt_d = cnt_q;
    case (st_q)
      RSW_ST_OFF: begin
        if (restart && !dis_next) begin
          st_d = RSW_ST_RUN;
        end
      end
      RSW_ST_RUN: begin
        if (expire) begin
          st_d = RSW_ST_EXP;
        end
      end
      RSW_ST_EXP: begin
        if (restart) begin
          st_d = RSW_ST_RUN;
        end
      end
      default: st_d = RSW_ST_OFF;
    endcase
    if (run_tick) begin
      cnt_d = expire ? 12'h000 : 12'(cnt_q - 12'h001);
    end
    // restart wins over a tick in the same cycle for the count, but an expiring tick still moves RSW_ST_RUN to RSW_ST_EXP unless disable is set
    if (restart) begin
      cnt_d = load_val;
      if (dis_next) begin
        st_d = RSW_ST_OFF;
      end
    end
  end

  // restart guard counted in slow periods
  always_comb begin
    guard_d = guard_q;
    if (ctrl_restart) begin
      guard_d = `RSW_GUARD_SLOW;
    end else if (slow_edge && guard_q != 2'h0) begin
      guard_d = 2'(guard_q - 2'h1);
    end
  end

  wire early_mode = wr_mode & (guard_q != 2'h0);

  // sticky status, set wins over read clear
  logic [1:0] stat_d;
  assign stat_d = (stat_q & ~{2{rd_stat}}) | {early_mode, expire};

  rsw_word_t rd_mux;
  logic      rd_ok;
  // unmapped reads answer zero with an error
  assign rd_ok  = sel_ctrl | sel_mode | sel_stat | sel_mask | sel_cnt;
  assign rd_mux = sel_mode ? mode_word :
                  sel_stat ? {30'h0, stat_q} :
                  sel_mask ? {30'h0, mask_q} :
                  sel_cnt  ? {20'h0, cnt_q} : 32'h0000_0000;

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      aw_held_q     <= 1'b0;
      w_held_q      <= 1'b0;
      awaddr_q      <= 8'h00;
      wdata_q       <= 32'h0000_0000;
      wstrb_q       <= 4'h0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RSW_RESP_OKAY;
    end else begin
      // readies stay low until the response is taken
      if (aw_take) begin
        aw_held_q     <= 1'b1;
        awaddr_q      <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_take) begin
        w_held_q     <= 1'b1;
        wdata_q      <= s_axi_wdata;
        wstrb_q      <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_do) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
      end
      if (b_done) begin
        s_axi_bvalid  <= 1'b0;
        aw_held_q     <= 1'b0;
        w_held_q      <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= `RSW_RESP_OKAY;
    end else if (ar_take) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_ok ? `RSW_RESP_OKAY : `RSW_RESP_SLVERR;
    end else if (r_done) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      reload_q <= `RSW_RLD_RESET;
      rsten_q  <= `RSW_RSTEN_RESET;
      dis_q    <= `RSW_DIS_RESET;
      mask_q   <= 2'h0;
    end else begin
      if (wr_mode) begin
        reload_q <= new_reload;
        rsten_q  <= new_rsten;
        dis_q    <= new_dis;
      end
      if (wr_mask) begin
        mask_q <= mask_new[1:0];
      end
    end
  end

  // output next values
  logic exp_next;
  logic rsten_next;
  logic irq_next;
  assign exp_next   = (st_d == RSW_ST_EXP);
  assign rsten_next = wr_mode ? new_rsten : rsten_q;
  assign irq_next   = |(stat_d & mask_q);

  // default watchdog running from reset
  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      st_q        <= RSW_ST_RUN;
      cnt_q       <= `RSW_RLD_RESET;
      guard_q     <= 2'h0;
      stat_q      <= 2'h0;
      irq_o       <= 1'b0;
      fault_o     <= 1'b0;
      wdt_reset_o <= 1'b0;
    end else begin
      st_q        <= st_d;
      cnt_q       <= cnt_d;
      guard_q     <= guard_d;
      stat_q      <= stat_d;
      irq_o       <= irq_next;
      fault_o     <= exp_next;
      wdt_reset_o <= exp_next & rsten_next;
    end
  end
endmodule

// ### src/rsw_defs.svh
`ifndef RSW_DEFS_SVH
`define RSW_DEFS_SVH

`define RSW_CTRL_OFF      8'h00
`define RSW_MODE_OFF      8'h04
`define RSW_STAT_OFF      8'h08
`define RSW_MASK_OFF      8'h0C
`define RSW_CNT_OFF       8'h10

`define RSW_CTRL_RESTART  0
`define RSW_MODE_RLD_MSB  11
`define RSW_MODE_RSTEN    13
`define RSW_MODE_DIS      15
`define RSW_STAT_EXPIRE   0
`define RSW_STAT_EARLY    1

`define RSW_RLD_RESET     12'hFFF
`define RSW_RSTEN_RESET   1'b1
`define RSW_DIS_RESET     1'b0

`define RSW_PRESCALE      8'h80
`define RSW_GUARD_SLOW    2'h3

`define RSW_RESP_OKAY     2'h0
`define RSW_RESP_SLVERR   2'h2

`endif

// ### src/rsw_pkg.sv
package rsw_pkg;
  typedef logic [31:0] rsw_word_t;
  typedef logic [7:0]  rsw_addr_t;
  typedef logic [3:0]  rsw_strb_t;
  typedef enum logic [2:0] {
    RSW_ST_OFF = 3'b001,
    RSW_ST_RUN = 3'b010,
    RSW_ST_EXP = 3'b100
  } rsw_state_t;
endpackage

// ### src/rsw_sync.sv
`timescale 1ns/100ps
module rsw_sync #(
  parameter int WIDTH = 4
) (
  input  wire logic             clk_sys_i,
  input  wire logic             sys_rst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta_q;

  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
          meta_q[g] <= 1'b0;
          sync_o[g] <= 1'b0;
        end else begin
          meta_q[g] <= async_i[g];
          sync_o[g] <= meta_q[g];
        end
      end
    end
  endgenerate
endmodule

// ### src/rsw_prescale.sv
`timescale 1ns/100ps
`include "rsw_defs.svh"
module rsw_prescale (
  input  wire logic clk_sys_i,
  input  wire logic sys_rst_i,
  input  wire logic use_rc_i,
  input  wire logic slow_s_i,
  input  wire logic rc_s_i,
  input  wire logic restart_i,
  output logic      tick_o,
  output logic      slow_edge_o
);
  logic       slow_prev_q;
  logic       rc_prev_q;
  logic [6:0] div_q;
  logic [6:0] div_d;
  wire        slow_rise = slow_s_i & ~slow_prev_q;
  wire        rc_rise   = rc_s_i & ~rc_prev_q;
  wire        base_rise = use_rc_i ? rc_rise : slow_rise;
  wire        div_wrap  = base_rise && ({1'b0, div_q} == 8'(`RSW_PRESCALE - 8'h01));

  // divide selected time base by 128
  assign div_d = restart_i ? 7'h00 : (base_rise ? 7'(div_q + 7'h01) : div_q);

  always_ff @(posedge clk_sys_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      slow_prev_q <= 1'b0;
      rc_prev_q   <= 1'b0;
      div_q       <= 7'h00;
      tick_o      <= 1'b0;
      slow_edge_o <= 1'b0;
    end else begin
      slow_prev_q <= slow_s_i;
      rc_prev_q   <= rc_s_i;
      div_q       <= div_d;
      tick_o      <= div_wrap & ~restart_i;
      slow_edge_o <= slow_rise;
    end
  end
endmodule

// ### sim/rsw_top_monitor.sv
`timescale 1ns/100ps
module rsw_top_monitor (
  input wire logic               clk_sys_i,
  input wire logic               sys_rst_i,
  input wire logic               s_axi_awready,
  input wire logic [1:0]         s_axi_bresp,
  input wire logic               s_axi_bvalid,
  input wire logic               s_axi_bready,
  input wire logic               s_axi_arvalid,
  input wire logic               s_axi_arready,
  input wire rsw_pkg::rsw_word_t s_axi_rdata,
  input wire logic               s_axi_rvalid,
  input wire logic               s_axi_rready,
  input wire logic               irq_o,
  input wire logic               fault_o,
  input wire logic               wdt_reset_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);
  chk_rst_defaults: assert property ($fell(sys_rst_i) |-> !fault_o && !wdt_reset_o && !irq_o)
    else $error("outputs not idle after reset");
  chk_reset_fault: assert property (wdt_reset_o |-> fault_o)
    else $error("reset out without fault");
  chk_reset_rise: assert property ($rose(wdt_reset_o) |-> $rose(fault_o))
    else $error("reset out rose apart from fault");
  chk_fault_clear: assert property ($fell(fault_o) |-> s_axi_bvalid)
    else $error("fault cleared without write");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  chk_aw_refused: assert property (s_axi_bvalid |-> !s_axi_awready)
    else $error("address taken during response");
  chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read answer late");
endmodule
bind rsw_top rsw_top_monitor u_mon (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .s_axi_awready(s_axi_awready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq_o(irq_o), .fault_o(fault_o),
  .wdt_reset_o(wdt_reset_o));

// ### sim/rsw_top_tb.sv
`timescale 1ns/100ps
`include "rsw_defs.svh"
module rsw_top_tb;
  import rsw_pkg::*;
  logic       clk_sys_i, sys_rst_i, slow_clk_i, rc_clk, rc_sel, pw_sel, slow_en, rc_en;
  logic       awv, awr, wv, wr_r, bv, br, arv, arr, rv, rr, irq_o, fault_o, rst_o;
  logic [1:0] bresp, rresp, rd_r, wb_r, ph;
  rsw_addr_t  awa, ara;
  rsw_word_t  wd, rdat, rd_v;
  rsw_strb_t  ws;
  int         error_cnt, n_compared, n, cyc;
  rsw_top dut (.clk_sys_i(clk_sys_i), .sys_rst_i(sys_rst_i), .slow_clk_i(slow_clk_i), .rc_div_clk_i(rc_clk),
    .main_rc_oscillator_enable_i(rc_sel), .primary_watchdog_on_slow_rc_i(pw_sel), .s_axi_awaddr(awa),
    .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
    .s_axi_wready(wr_r), .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara),
    .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
    .s_axi_rready(rr), .irq_o(irq_o), .fault_o(fault_o), .wdt_reset_o(rst_o));
  initial begin
    clk_sys_i = 1'b0;
    forever #5 clk_sys_i = ~clk_sys_i;
  end
  // time bases at a quarter of clk_sys_i, still when off
  always @(posedge clk_sys_i) begin
    ph <= ph + 2'h1;
    slow_clk_i <= slow_en & ph[1];
    rc_clk <= rc_en & ph[1];
  end
  task automatic results();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic check(input string name, input rsw_word_t exp, input rsw_word_t got);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic hang(input int i);
    if (i >= 50) begin
      error_cnt++;
      $display("[FAIL] handshake expected done seen timeout");
      results();
    end
  endtask
  task automatic wr(input rsw_addr_t a, input rsw_word_t d);
    int i;
    awa <= a;
    wd <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_i);
      if (awv && awr) awv <= 1'b0;
      if (wv && wr_r) wv <= 1'b0;
      if ((!awv || awr) && (!wv || wr_r)) break;
    end
    hang(i);
    repeat ($urandom_range(2)) @(posedge clk_sys_i);
    br <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_i);
      if (bv === 1'b1) break;
    end
    hang(i);
    wb_r = bresp;
    br <= 1'b0;
  endtask
  task automatic rd(input rsw_addr_t a);
    int i;
    ara <= a;
    arv <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_i);
      if (arr === 1'b1) break;
    end
    hang(i);
    arv <= 1'b0;
    repeat ($urandom_range(2)) @(posedge clk_sys_i);
    rr <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk_sys_i);
      if (rv === 1'b1) break;
    end
    hang(i);
    rd_v = rdat;
    rd_r = rresp;
    rr <= 1'b0;
  endtask
  function automatic rsw_word_t mode_word(input int r, input logic en);
    mode_word = 32'(r) | ({31'h0, en} << 13);
  endfunction
  initial begin
    {slow_en, rc_en, rc_sel, pw_sel, awv, wv, br, arv, rr, slow_clk_i, rc_clk} = '0;
    {ph, awa, ara, wd} = '0;
    ws = 4'hF;
    error_cnt = 0;
    n_compared = 0;
    sys_rst_i = 1'b1;
    void'($urandom(32'h0B59));
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(`RSW_MODE_OFF);
    check("mode", mode_word(32'hFFF, 1'b1), rd_v);
    rd(`RSW_CNT_OFF);
    check("count", 32'hFFF, rd_v);
    rd(8'h20);
    check("resp", 32'h2, {30'h0, rd_r});
    check("rdata", 32'h0, rd_v);
    wr(8'h20, 32'h1);
    check("bresp", {30'h0, `RSW_RESP_SLVERR}, {30'h0, wb_r});
    wr(`RSW_MASK_OFF, 32'h1);
    check("bresp", {30'h0, `RSW_RESP_OKAY}, {30'h0, wb_r});
    for (int k = 0; k < 3; k++) begin
      n = $urandom_range(9, 6);
      slow_en <= (k == 0);
      rc_en <= (k != 0);
      rc_sel <= (k == 1);
      pw_sel <= (k == 2);
      wr(`RSW_MODE_OFF, mode_word(n, k != 1));
      for (cyc = 0; cyc < n * 512 + 40 && fault_o !== 1'b1; cyc++) @(posedge clk_sys_i);
      check("expiry", 32'h1, {31'h0, cyc >= n * 512 - 10 && cyc <= n * 512 + 10});
      check("rst_out", {31'h0, k != 1}, {31'h0, rst_o});
      check("irq", 32'h1, {31'h0, irq_o});
      rd(`RSW_STAT_OFF);
      check("status", 32'h1, rd_v);
      rd(`RSW_CNT_OFF);
      check("count", 32'h0, rd_v);
      check("irq", 32'h0, {31'h0, irq_o});
    end
    wr(`RSW_CTRL_OFF, 32'h1);
    check("fault", 32'h0, {31'h0, fault_o});
    wr(`RSW_MODE_OFF, mode_word(6, 1'b1));
    rd(`RSW_STAT_OFF);
    check("status", 32'h2, rd_v);
    slow_en <= 1'b1;
    wr(`RSW_CTRL_OFF, 32'h1);
    repeat (24) @(posedge clk_sys_i);
    wr(`RSW_MODE_OFF, mode_word(6, 1'b1));
    rd(`RSW_STAT_OFF);
    check("status", 32'h0, rd_v);
    wr(`RSW_MODE_OFF, 32'h0000_8000);
    repeat (600) @(posedge clk_sys_i);
    check("fault", 32'h0, {31'h0, fault_o});
    rd(`RSW_CNT_OFF);
    check("count", 32'h0, rd_v);
    ws <= 4'h1;
    wr(`RSW_MODE_OFF, 32'h0000_20AB);
    ws <= 4'hF;
    rd(`RSW_MODE_OFF);
    check("mode", 32'h0000_80AB, rd_v);
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    @(posedge clk_sys_i);
    rd(`RSW_MODE_OFF);
    check("mode", mode_word(32'hFFF, 1'b1), rd_v);
    rd(`RSW_MASK_OFF);
    check("mask", 32'h0, rd_v);
    results();
  end
endmodule
